/* File: design/sebio_ports.sv */
// two general-purpose ports (six and eight bits) behind an apb slave
module sebio_ports #(
    parameter int PA_W          = 6,  // port a width
    parameter int PB_W          = 8,  // port b width
    parameter bit HAS_CONVERTER = 1   // analog selection present
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    // apb slave
    input  wire logic [11:0]     paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // port a pins
    input  wire logic [PA_W-1:0] pa_in,
    output logic      [PA_W-1:0] pa_out,
    output logic      [PA_W-1:0] pa_oe,
    // port a peripheral sharing
    input  wire logic [PA_W-1:0] periph_a_sel,
    input  wire logic [PA_W-1:0] periph_a_out,
    input  wire logic [PA_W-1:0] periph_a_oe,
    // port b pins
    input  wire logic [PB_W-1:0] pb_in,
    output logic      [PB_W-1:0] pb_out,
    output logic      [PB_W-1:0] pb_oe,
    output logic      [PB_W-1:0] pb_pullup,
    // port b peripheral sharing
    input  wire logic [PB_W-1:0] periph_b_sel,
    input  wire logic [PB_W-1:0] periph_b_out,
    input  wire logic [PB_W-1:0] periph_b_oe,
    // alternate inputs and status
    output logic                 timer0_clock_in,
    output logic                 ext_interrupt_in,
    output logic                 prog_clock_in,
    output logic                 prog_data_in,
    output logic      [PA_W-1:0] analog_select,
    output logic                 change_flag,
    output logic                 wake_request
);
    // the register map and field layout assume these exact widths
    if (PA_W != 6 || PB_W != 8) begin : g_bad_width
        $error("sebio_ports: port widths must be 6 and 8");
    end

    localparam int CHG_W = PB_W - sebio_pkg::CHG_LO;  // change-detect pins

    // port state
    logic [PA_W-1:0]  port_a_data;     // port a output latch
    logic [PA_W-1:0]  port_a_dir;      // port a direction, 1 = input
    logic [PB_W-1:0]  port_b_data;     // port b output latch
    logic [PB_W-1:0]  port_b_dir;      // port b direction, 1 = input
    logic [7:0]       option_reg;      // option register, bit 7 pull-up control
    logic [2:0]       pin_config;      // converter configuration field
    logic [CHG_W-1:0] old_b;           // value latched at last port b access

    // synchronised pin views
    logic [PA_W-1:0]  sync_a;          // port a pins after synchroniser
    logic [PB_W-1:0]  sync_b;          // port b pins after synchroniser
    logic [PA_W-1:0]  analog_mask;     // pins currently analog
    logic [PA_W-1:0]  a_view;          // port a value seen by software
    logic [CHG_W-1:0] mismatch_bits;   // per-pin change comparison
    logic             mismatch;        // any change pending

    // bus decode
    logic             setup_ph;        // first cycle of a transfer
    logic             access_ph;       // completing cycle of a transfer
    logic             mapped;          // address hits a register
    logic             wr_done;         // write completes this edge
    logic             rd_done;         // read completes this edge
    logic [7:0]       bit_mask;        // bits a write actually changes
    logic [7:0]       rd_value;        // read mux output

    // pins pass four flops before any use
    // pin synchronisers
    sebio_sync #(.W(PA_W)) u_sync_a (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (pa_in),
        .q       (sync_a)
    );

    sebio_sync #(.W(PB_W)) u_sync_b (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (pb_in),
        .q       (sync_b)
    );

    // analog selection; without the converter every pin stays digital
    // analog pin decode
    assign analog_mask   = HAS_CONVERTER ? sebio_pkg::sebio_analog_mask(pin_config) : '0;
    assign analog_select = analog_mask;

    // analog pins read as zero, digital ones show the pin level
    // pin read view
    assign a_view = sync_a & ~analog_mask;

    // apb phases; the slave never waits
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign pready    = 1'b1;
    assign wr_done   = access_ph && pwrite && mapped;
    assign rd_done   = access_ph && !pwrite && mapped;

    // a non-zero mask in byte one selects single bits, else whole byte
    assign bit_mask = (pwdata[15:8] == 8'h00) ? 8'hff : pwdata[15:8];

    // address decode; high address bits must be zero
    always_comb begin
        mapped = 1'b0;
        if (paddr[11:10] == 2'b00) begin
            case (paddr[9:2])
                sebio_pkg::IDX_PA_DATA,
                sebio_pkg::IDX_PB_DATA,
                sebio_pkg::IDX_INTCTL,
                sebio_pkg::IDX_OPTION,
                sebio_pkg::IDX_PA_DIR,
                sebio_pkg::IDX_PB_DIR,
                sebio_pkg::IDX_CONV_ONE: mapped = 1'b1;
                default:                 mapped = 1'b0;
            endcase
        end
    end

    // unmapped access is flagged in its access cycle
    assign pslverr = access_ph && !mapped;

    // read mux; unused bits stay zero
    // zero fill
    always_comb begin
        rd_value = 8'h00;
        case (paddr[9:2])
            sebio_pkg::IDX_PA_DATA:  rd_value = {2'b00, a_view};
            sebio_pkg::IDX_PB_DATA:  rd_value = sync_b;
            sebio_pkg::IDX_INTCTL:   rd_value = {7'h00, change_flag};
            sebio_pkg::IDX_OPTION:   rd_value = option_reg;
            sebio_pkg::IDX_PA_DIR:   rd_value = {2'b00, port_a_dir};
            sebio_pkg::IDX_PB_DIR:   rd_value = port_b_dir;
            sebio_pkg::IDX_CONV_ONE: rd_value = {5'h00, pin_config};
            default:                 rd_value = 8'h00;
        endcase
    end

    // read data captured in setup so it is a flop in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata <= {24'h00_0000, rd_value};
        end
    end

    // port a latch: pins read, change merged, result stored
    // port a merge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_data <= sebio_pkg::LATCH_RST[PA_W-1:0];
        end else if (wr_done && paddr[9:2] == sebio_pkg::IDX_PA_DATA) begin
            port_a_data <= (a_view & ~bit_mask[PA_W-1:0])
                         | (pwdata[PA_W-1:0] & bit_mask[PA_W-1:0]);
        end
    end

    // port b latch, same merge; output pins keep their level
    // port b merge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_data <= sebio_pkg::LATCH_RST;
        end else if (wr_done && paddr[9:2] == sebio_pkg::IDX_PB_DATA) begin
            port_b_data <= (sync_b & ~bit_mask) | (pwdata[7:0] & bit_mask);
        end
    end

    // direction registers; reset makes every pin an input
    // inputs at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_dir <= sebio_pkg::PA_DIR_RST;
            port_b_dir <= sebio_pkg::PB_DIR_RST;
        end else if (wr_done) begin
            if (paddr[9:2] == sebio_pkg::IDX_PA_DIR) begin
                port_a_dir <= pwdata[PA_W-1:0];
            end
            if (paddr[9:2] == sebio_pkg::IDX_PB_DIR) begin
                port_b_dir <= pwdata[7:0];
            end
        end
    end

    // option register and converter field
    // pull-ups off at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_reg <= sebio_pkg::OPTION_RST;
            pin_config <= sebio_pkg::CONV_RST;
        end else if (wr_done) begin
            if (paddr[9:2] == sebio_pkg::IDX_OPTION) begin
                option_reg <= pwdata[7:0];
            end
            if (paddr[9:2] == sebio_pkg::IDX_CONV_ONE) begin
                pin_config <= pwdata[2:0];
            end
        end
    end

    // port a pin drivers, one slice per pin
    for (genvar i = 0; i < PA_W; i++) begin : g_pa
        always_comb begin
            if (periph_a_sel[i]) begin
                pa_out[i] = periph_a_out[i];
                pa_oe[i]  = periph_a_oe[i];
            end else if (i == sebio_pkg::T0CK_BIT) begin
                pa_out[i] = 1'b0;
                pa_oe[i]  = !port_a_dir[i] && !port_a_data[i];
            end else begin
                pa_out[i] = port_a_data[i];
                pa_oe[i]  = !port_a_dir[i];
            end
        end
    end

    // port b pin drivers and pull-ups
    for (genvar i = 0; i < PB_W; i++) begin : g_pb
        always_comb begin
            if (periph_b_sel[i]) begin
                pb_out[i] = periph_b_out[i];
                pb_oe[i]  = periph_b_oe[i];
            end else begin
                pb_out[i] = port_b_data[i];
                pb_oe[i]  = !port_b_dir[i];
            end
        end
        assign pb_pullup[i] = !option_reg[sebio_pkg::PULLUP_N_BIT] && port_b_dir[i]
                            && !periph_b_sel[i];
    end

    // alternate inputs; schmitt buffering is in the pad, here clean levels
    // timer, interrupt and programming inputs
    assign timer0_clock_in  = sync_a[sebio_pkg::T0CK_BIT];
    assign ext_interrupt_in = sync_b[sebio_pkg::EXTINT_BIT];
    assign prog_clock_in    = sync_b[sebio_pkg::PROG_CK_BIT];
    assign prog_data_in     = sync_b[sebio_pkg::PROG_DA_BIT];

    // only input pins of the upper half take part
    // input-only comparison
    assign mismatch_bits = (sync_b[PB_W-1:sebio_pkg::CHG_LO] ^ old_b)
                         & port_b_dir[PB_W-1:sebio_pkg::CHG_LO];
    assign mismatch = |mismatch_bits;

    // relatch on any port b access; a read keeps the value it returned
    // so a change between setup and access is not swallowed
    // access relatches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            old_b <= '0;
        end else if (access_ph && mapped && paddr[9:2] == sebio_pkg::IDX_PB_DATA) begin
            old_b <= pwrite ? sync_b[PB_W-1:sebio_pkg::CHG_LO]
                            : prdata[PB_W-1:sebio_pkg::CHG_LO];
        end
    end

    // change flag; a live mismatch beats a software clear
    // set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_flag <= 1'b0;
        end else if (mismatch) begin
            change_flag <= 1'b1;
        end else if (wr_done && paddr[9:2] == sebio_pkg::IDX_INTCTL
                     && !pwdata[sebio_pkg::CHANGE_BIT]) begin
            change_flag <= 1'b0;
        end
    end

    // wake request follows the flag so sleep logic sees a stable level
    // wake on change
    assign wake_request = change_flag;

    // direction bit high means no drive, unless a peripheral owns the pin
    inputs_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((pa_oe & port_a_dir & ~periph_a_sel) == '0)
        && ((pb_oe & port_b_dir & ~periph_b_sel) == '0))
        else $error("input pin driven");

    // the open-drain pin never drives high while no peripheral owns it
    open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
        !periph_a_sel[sebio_pkg::T0CK_BIT] |->
        !(pa_oe[sebio_pkg::T0CK_BIT] && port_a_data[sebio_pkg::T0CK_BIT]))
        else $error("open drain pin drove high");

    // pull-up control bit set keeps every pull-up off
    pullup_global_a: assert property (@(posedge pclk) disable iff (!presetn)
        option_reg[sebio_pkg::PULLUP_N_BIT] |-> (pb_pullup == '0))
        else $error("pull-up on while disabled");

    // no output pin carries a pull-up
    pullup_output_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pb_pullup & ~port_b_dir) == '0)
        else $error("pull-up on output pin");

    // a mismatch sets the flag on the next edge
    change_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        mismatch |=> change_flag)
        else $error("mismatch did not set flag");

    // a clear during a mismatch is lost, for two cycles in a row
    clear_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mismatch && wr_done && paddr[9:2] == sebio_pkg::IDX_INTCTL)
        |=> change_flag ##1 (change_flag || !$past(mismatch)))
        else $error("flag cleared during mismatch");

    // a port b read relatches exactly the value it returned
    relatch_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr[9:2] == sebio_pkg::IDX_PB_DATA)
        |=> old_b == $past(prdata[PB_W-1:sebio_pkg::CHG_LO]))
        else $error("compare latch not updated");

    // port a read returns pins with analog and upper bits zero
    read_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr[9:2] == sebio_pkg::IDX_PA_DATA
         && paddr[11:10] == 2'b00)
        |=> prdata[7:0] == {2'b00, $past(sync_a) & ~$past(analog_mask)})
        else $error("port a read wrong");

    // unused converter bits always read zero
    conv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr[9:2] == sebio_pkg::IDX_CONV_ONE)
        |=> prdata[7:3] == 5'h00 ##0 prdata[2:0] == $past(pin_config))
        else $error("converter read wrong");

    // main scenarios
    change_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        !change_flag ##1 change_flag);
    flag_cleared_c: cover property (@(posedge pclk) disable iff (!presetn)
        change_flag ##1 !change_flag);
    output_drive_c: cover property (@(posedge pclk) disable iff (!presetn)
        (pa_oe != '0) && (pb_oe != '0));
    unmapped_c: cover property (@(posedge pclk) disable iff (!presetn)
        pslverr);
endmodule

/* File: design/sebio_pkg.sv */
package sebio_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PA_DATA  = 8'h05;
    localparam logic [7:0] IDX_PB_DATA  = 8'h06;
    localparam logic [7:0] IDX_INTCTL   = 8'h0b;
    localparam logic [7:0] IDX_OPTION   = 8'h81;
    localparam logic [7:0] IDX_PA_DIR   = 8'h85;
    localparam logic [7:0] IDX_PB_DIR   = 8'h86;
    localparam logic [7:0] IDX_CONV_ONE = 8'h9f;
    // reset values
    localparam logic [5:0] PA_DIR_RST   = 6'h3f;
    localparam logic [7:0] PB_DIR_RST   = 8'hff;
    localparam logic [7:0] OPTION_RST   = 8'hff;
    localparam logic [2:0] CONV_RST     = 3'h0;
    localparam logic [7:0] LATCH_RST    = 8'h00;
    // field positions
    localparam int PULLUP_N_BIT = 7;
    localparam int CHANGE_BIT   = 0;
    localparam int T0CK_BIT     = 4;
    localparam int EXTINT_BIT   = 0;
    localparam int PROG_CK_BIT  = 6;
    localparam int PROG_DA_BIT  = 7;
    localparam int CHG_LO       = 4;
    // analog pin mask per pin configuration code
    function automatic logic [5:0] sebio_analog_mask(input logic [2:0] cfg);
        logic [5:0] m;
        m = 6'h00;
        case (cfg)
            3'h0, 3'h1, 3'h2: m = 6'h2f;
            3'h3:             m = 6'h0f;
            3'h4, 3'h5:       m = 6'h0b;
            default:          m = 6'h00;
        endcase
        return m;
    endfunction
endpackage

/* File: design/sebio_sync.sv */
// three-stage pin synchroniser; output moves once stages two and three agree
module sebio_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;   // metastability catcher, read by s2 only
    logic [W-1:0] s2;   // second stage
    logic [W-1:0] s3;   // third stage

    // shift chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // per bit, accept a level only when two stages agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                q[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
                q[i] <= s3[i];
            end
        end
    end
endmodule

/* File: tb/sebio_board.sv */
// board around the two ports: external drivers, weak pull-ups, floating lines
module sebio_board (
    input  wire logic       pclk,
    input  wire logic [5:0] pa_out,
    input  wire logic [5:0] pa_oe,
    input  wire logic [5:0] ext_a,
    input  wire logic [5:0] ext_a_en,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pb_pullup,
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_b_en,
    output logic      [5:0] pa_in,
    output logic      [7:0] pb_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] pa_hold = 6'h00;  // level a released line drifts to
    logic [7:0] pb_hold = 8'h00;  // same for port b
    logic [5:0] pa_drv;           // someone drives the line
    logic [7:0] pb_drv;           // someone drives the line
    assign pa_drv = pa_oe | ext_a_en;
    assign pb_drv = pb_oe | ext_b_en;
    // device driver wins, board second; a floating line never keeps its old value
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a_en & ext_a) | (~pa_drv & pa_hold);
    // pull-up pulls an undriven line high
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b_en & ext_b)
                 | (~pb_drv & pb_pullup) | (~pb_drv & ~pb_pullup & pb_hold);
    // remember the inverse of the last driven level
    always_ff @(posedge pclk) begin
        pa_hold <= (~pa_drv & pa_hold) | (pa_drv & ~pa_in);
        pb_hold <= (~pb_drv & pb_hold) | (pb_drv & ~pb_in);
    end
endmodule

/* File: tb/testbench.sv */
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr;
    logic [5:0] pa_in, pa_out, pa_oe, ext_a = 6'h3f, ext_a_en = 6'h3f, analog_select;
    logic [5:0] psel_a = 6'h00, pout_a = 6'h00, poe_a = 6'h00;
    logic [7:0] pb_in, pb_out, pb_oe, pb_pullup, ext_b = 8'h00, ext_b_en = 8'hff;
    logic t0ck, extint, progck, progda, change_flag, wake_request;
    logic [7:0] rd;  // last read byte
    logic err;       // last error response
    int num_errors = 0, num_checks = 0, cycles = 0;
    initial forever #5 pclk = ~pclk;
    sebio_ports i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
        .periph_a_sel(psel_a), .periph_a_out(pout_a), .periph_a_oe(poe_a),
        .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
        .periph_b_sel(8'h00), .periph_b_out(8'h00), .periph_b_oe(8'h00),
        .timer0_clock_in(t0ck), .ext_interrupt_in(extint), .prog_clock_in(progck),
        .prog_data_in(progda), .analog_select(analog_select), .change_flag(change_flag),
        .wake_request(wake_request));
    sebio_board i_board (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe), .ext_a(ext_a),
        .ext_a_en(ext_a_en), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
        .ext_b(ext_b), .ext_b_en(ext_b_en), .pa_in(pa_in), .pb_in(pb_in));
    // one apb transfer; holds the request until pready is seen high
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [15:0] wd);
        @(posedge pclk);
        paddr <= {2'b00, idx, 2'b00};
        pwrite <= wr;
        pwdata <= {16'h0000, wd};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr8(input logic [7:0] idx, input logic [7:0] v);
        xfer(idx, 1'b1, {8'h00, v});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // reset values, read-zero bits and an unmapped place
    task automatic t_reset;
        logic [7:0] idx[6] = '{sebio_pkg::IDX_PA_DIR, sebio_pkg::IDX_PB_DIR,
            sebio_pkg::IDX_OPTION, sebio_pkg::IDX_CONV_ONE, sebio_pkg::IDX_INTCTL, 8'h10};
        logic [7:0] exp[6] = '{8'h3f, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            xfer(idx[i], 1'b0, 16'h0000);
            `CHK("reset reg", exp[i], rd)
            `CHK("slave error", (i == 5), err)
        end
        xfer(sebio_pkg::IDX_PA_DATA, 1'b0, 16'h0000);
        `CHK("port a after reset", 8'h10, rd)
        `CHK("analog pins", 6'h2f, analog_select)
        `CHK("port a drive", 6'h00, pa_oe)
        `CHK("pull-ups", 8'h00, pb_pullup)
        $display("test reset done");
    endtask
    // port a outputs, open-drain bit 4, pin readback
    task automatic t_port_a;
        // upper bits written as ones must read back zero; code 3 keeps pins 0..3 analog
        wr8(sebio_pkg::IDX_CONV_ONE, 8'hfb);
        xfer(sebio_pkg::IDX_CONV_ONE, 1'b0, 16'h0000);
        `CHK("converter readback", 8'h03, rd)
        `CHK("analog pins code 3", 6'h0f, analog_select)
        wr8(sebio_pkg::IDX_CONV_ONE, 8'h04);
        settle(1);
        `CHK("analog pins code 4", 6'h0b, analog_select)
        wr8(sebio_pkg::IDX_CONV_ONE, 8'h06);
        wr8(sebio_pkg::IDX_PA_DIR, 8'h00);
        wr8(sebio_pkg::IDX_PA_DATA, 8'h25);
        settle(1);
        `CHK("pa out", 6'h25, pa_out)
        `CHK("pa oe low bit4", 6'h3f, pa_oe)
        wr8(sebio_pkg::IDX_PA_DATA, 8'h15);
        // pin change needs four edges through the synchroniser before a read sees it
        settle(5);
        `CHK("pa out open drain", 6'h05, pa_out)
        `CHK("pa oe released", 6'h2f, pa_oe)
        xfer(sebio_pkg::IDX_PA_DATA, 1'b0, 16'h0000);
        `CHK("pa pins", 8'h15, rd)
        psel_a <= 6'h01;
        pout_a <= 6'h00;
        poe_a <= 6'h01;
        settle(1);
        `CHK("periph owns pin", 6'h14, {pa_oe[5:1] & ~pa_out[5:1], pa_out[0]} ^ 6'h3e)
        psel_a <= 6'h00;
        settle(6);
        `CHK("timer clock in", 1'b1, t0ck)
        $display("test port a done");
    endtask
    // read-modify-write merge, port b direction and pull-ups
    task automatic t_port_b;
        ext_b <= 8'ha0;
        wr8(sebio_pkg::IDX_PB_DIR, 8'hf0);
        xfer(sebio_pkg::IDX_PB_DATA, 1'b1, 16'h0f03);
        settle(1);
        `CHK("pb oe", 8'h0f, pb_oe)
        `CHK("pb low out", 4'h3, pb_out[3:0])
        wr8(sebio_pkg::IDX_PB_DIR, 8'h00);
        settle(1);
        `CHK("merged latch", 8'ha3, pb_out)
        wr8(sebio_pkg::IDX_PB_DIR, 8'hf0);
        wr8(sebio_pkg::IDX_OPTION, 8'h7f);
        settle(1);
        `CHK("pull-ups on inputs", 8'hf0, pb_pullup)
        wr8(sebio_pkg::IDX_OPTION, 8'hff);
        settle(1);
        `CHK("pull-ups off", 8'h00, pb_pullup)
        $display("test port b done");
    endtask
    // change flag: set, refused clear, relatch, exclusion of outputs and low pins
    task automatic t_change;
        ext_b <= 8'h00;
        wr8(sebio_pkg::IDX_PB_DIR, 8'hff);
        settle(6);
        xfer(sebio_pkg::IDX_PB_DATA, 1'b0, 16'h0000);
        wr8(sebio_pkg::IDX_INTCTL, 8'h00);
        settle(1);
        `CHK("flag clear", 1'b0, change_flag)
        // no port b reads while waiting
        ext_b <= 8'h20;
        settle(6);
        `CHK("flag set", 1'b1, change_flag)
        `CHK("wake", 1'b1, wake_request)
        wr8(sebio_pkg::IDX_INTCTL, 8'h00);
        settle(1);
        `CHK("clear refused", 1'b1, change_flag)
        xfer(sebio_pkg::IDX_PB_DATA, 1'b0, 16'h0000);
        `CHK("pb read", 8'h20, rd)
        wr8(sebio_pkg::IDX_INTCTL, 8'h00);
        settle(1);
        `CHK("flag cleared", 1'b0, change_flag)
        wr8(sebio_pkg::IDX_PB_DIR, 8'h7f);
        ext_b <= 8'h21;
        settle(10);
        `CHK("outputs and low pins ignored", 1'b0, change_flag)
        `CHK("ext interrupt in", 1'b1, extint)
        `CHK("prog data in", 1'b1, progda)
        ext_b <= 8'h61;
        settle(6);
        `CHK("prog clock in", 1'b1, progck)
        `CHK("one synced change", 1'b1, change_flag)
        $display("test change done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard well above the roughly 140 cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_port_a();
        t_port_b();
        t_change();
        complete_run();
    end
endmodule
